// ### hdl/srs_pkg.sv
// How it works
// - control bank only in configuration; 8-bit registers
// - results only in measurement; 16-bit, counter 24-bit
// - counter split: low word, then top byte, 00h
// - result words go out low byte first
// - result read may start at any address
// - after last valid address pointer returns to 2h
// - counter words exist only with enable in sync mode
// - only low four address bits are decoded
// - measurement map: state/status, temperature, X, Y, Z
// - power-up gives configuration state with power-down on
// - ready low at conversion start, high at end
// - 010b enters configuration, clears results, keeps configuration
// - no wrap when pointer lies above result space
// - reset loads documented control bank values
// - reserved address 1 reads 00h
// - control registers read back their contents
// - measurement state blocks control bank except state register
// - pointer advances after every stored write byte
// - shortened read starts at 2h or 0h
package srs_pkg;

  // control bank addresses
  localparam logic [3:0] ADDR_STCTL = 4'h0;
  localparam logic [3:0] ADDR_RSV1 = 4'h1;
  localparam logic [3:0] ADDR_GEN_ID = 4'h2;
  localparam logic [3:0] ADDR_RSV3 = 4'h3;
  localparam logic [3:0] ADDR_RSV4 = 4'h4;
  localparam logic [3:0] ADDR_RSV5 = 4'h5;
  localparam logic [3:0] ADDR_CFG1 = 4'h6;
  localparam logic [3:0] ADDR_CFG2 = 4'h7;
  localparam logic [3:0] ADDR_CFG3 = 4'h8;
  localparam logic [3:0] ADDR_PAUSE = 4'h9;
  localparam logic [3:0] ADDR_SYNC_EDGE_COUNT = 4'hA;
  localparam logic [3:0] ADDR_OPT = 4'hB;

  // result bank addresses
  localparam logic [3:0] RES_TEMP = 4'h1;
  localparam logic [3:0] RES_X = 4'h2;
  localparam logic [3:0] RES_Y = 4'h3;
  localparam logic [3:0] RES_Z = 4'h4;
  localparam logic [3:0] RES_CT_LO = 4'h5;
  localparam logic [3:0] RES_CT_HI = 4'h6;
  localparam logic [3:0] RES_WRAP = 4'h2;
  localparam logic [3:0] RES_LAST_NO_TM = 4'h4;
  localparam logic [3:0] RES_LAST_TM = 4'h6;
  localparam logic [3:0] START_IDX_MEAS = 4'h2;
  localparam logic [3:0] START_IDX_CFG = 4'h0;

  // reset values
  localparam logic [7:0] RST_STCTL = 8'h42;
  localparam logic [7:0] RST_RSV1 = 8'h00;
  localparam logic [7:0] RST_RSV3 = 8'h00;
  localparam logic [7:0] RST_RSV4 = 8'hFF;
  localparam logic [7:0] RST_RSV5 = 8'h80;
  localparam logic [7:0] RST_CFG1 = 8'hA6;
  localparam logic [7:0] RST_CFG2 = 8'h40;
  localparam logic [7:0] RST_CFG3 = 8'h40;
  localparam logic [7:0] RST_PAUSE = 8'h19;
  localparam logic [7:0] RST_SYNC_EDGE_COUNT = 8'h01;
  localparam logic [7:0] RST_OPT = 8'h73;
  localparam logic [7:0] FILL_BYTE = 8'h00;

  // state register fields
  localparam int STCTL_SS = 7;
  localparam int STCTL_PD = 6;
  localparam int STCTL_SWRES = 3;
  localparam logic [2:0] OPST_CONFIG = 3'h2;
  localparam logic [2:0] OPST_MEAS = 3'h3;

  // option fields inside the control bank
  localparam int CFG2_TM_EN = 6;
  localparam int CFG3_MODE_HI = 7;
  localparam int CFG3_MODE_LO = 6;
  localparam logic [1:0] MODE_EXT_SYNC = 2'h3;
  localparam int OPT_START_IDX = 0;

  // byte commands from the serial front end
  localparam logic [1:0] CMD_PTR = 2'h0;
  localparam logic [1:0] CMD_WR = 2'h1;
  localparam logic [1:0] CMD_RD = 2'h2;
  localparam logic [1:0] CMD_SHORT = 2'h3;

  typedef enum logic [1:0] {
    SRS_ST_CONFIG = 2'b01,
    SRS_ST_MEAS = 2'b10
  } srs_state_t;

endpackage

// ### hdl/srs_regspace.sv
`timescale 1ns/1ps
`default_nettype none
module srs_regspace #(
  parameter int ADDR_W = 4,
  parameter int CT_W = 24,
  parameter logic [7:0] GEN_ID = 8'h5A // arbitrary value
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // link side, runs on the serial front end clock
  input wire logic link_clk_i,
  input wire logic lk_cmd_valid_i,
  input wire logic [1:0] lk_cmd_i,
  input wire logic [7:0] lk_data_i,
  output logic lk_busy_o,
  output logic lk_rvalid_o,
  output logic [7:0] lk_rdata_o,
  // measurement core, system clock
  input wire logic conv_start_i,
  input wire logic conv_done_i,
  input wire logic [7:0] status_i,
  input wire logic [15:0] temp_i,
  input wire logic [15:0] x_i,
  input wire logic [15:0] y_i,
  input wire logic [15:0] z_i,
  input wire logic [23:0] conv_time_i,
  output logic ready_o,
  output logic meas_state_o,
  output logic power_down_o,
  output logic start_meas_o,
  output logic [7:0] config_gain_time_o,
  output logic [7:0] config_second_o,
  output logic [7:0] config_third_o,
  output logic [7:0] inter_measure_pause_o,
  output logic [7:0] sync_edge_count_o,
  output logic [7:0] option_settings_o
);

  if (ADDR_W != 4 || CT_W != 24) begin : g_bad_param
    $error("srs_regspace: only ADDR_W=4 and CT_W=24 are supported");
  end

  // ---------------- link domain ----------------
  logic [1:0] lk_cmd_q;
  logic [7:0] lk_data_q;
  logic req_tog;
  logic ack_m;
  logic ack_s;
  logic ack_seen;
  logic ack_tog;
  logic [7:0] rd_byte;
  wire lk_take = lk_cmd_valid_i && !lk_busy_o;
  wire lk_ack_new = ack_s != ack_seen;

  // one command in flight; busy holds off the front end until the ack returns
  assign lk_busy_o = req_tog != ack_seen;

  // capture command and flip the request toggle in the same edge
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lk_cmd_q <= 2'h0;
      lk_data_q <= 8'h00;
      req_tog <= 1'b0;
    end else if (lk_take) begin
      lk_cmd_q <= lk_cmd_i;
      lk_data_q <= lk_data_i;
      req_tog <= ~req_tog;
    end
  end

  // ack toggle synchroniser; read byte is static once the ack is seen
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_m <= 1'b0;
      ack_s <= 1'b0;
      ack_seen <= 1'b0;
      lk_rvalid_o <= 1'b0;
      lk_rdata_o <= 8'h00;
    end else begin
      ack_m <= ack_tog;
      ack_s <= ack_m;
      ack_seen <= ack_s;
      lk_rvalid_o <= lk_ack_new && (lk_cmd_q == srs_pkg::CMD_RD);
      if (lk_ack_new && (lk_cmd_q == srs_pkg::CMD_RD)) begin
        lk_rdata_o <= rd_byte;
      end
    end
  end

  // ---------------- system domain ----------------
  logic req_m;
  logic req_s;
  logic req_seen;
  srs_pkg::srs_state_t state;
  logic stc_ss;
  logic stc_pd;
  logic [7:0] cfg1;
  logic [7:0] cfg2;
  logic [7:0] cfg3;
  logic [7:0] pause;
  logic [7:0] sync_edge_count;
  logic [7:0] opt;
  logic [15:0] res_temp;
  logic [15:0] res_x;
  logic [15:0] res_y;
  logic [15:0] res_z;
  logic [23:0] res_ct;
  logic [3:0] ptr;
  logic hi_phase;

  // request toggle synchroniser; only req_s is looked at by logic
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
    end else if (ce_i) begin
      req_m <= req_tog;
      req_s <= req_m;
    end
  end

  // command decode; link holding regs are stable while the request is open
  wire new_req = ce_i && (req_s != req_seen);
  wire in_meas = state == srs_pkg::SRS_ST_MEAS;
  wire do_ptr = new_req && (lk_cmd_q == srs_pkg::CMD_PTR);
  wire do_wr = new_req && (lk_cmd_q == srs_pkg::CMD_WR);
  wire do_rd = new_req && (lk_cmd_q == srs_pkg::CMD_RD);
  wire do_short = new_req && (lk_cmd_q == srs_pkg::CMD_SHORT);
  wire [3:0] addr_in = lk_data_q[3:0];
  wire stc_wr = do_wr && (ptr == srs_pkg::ADDR_STCTL);
  wire cfg_wr = do_wr && !in_meas;
  wire [2:0] opst_in = lk_data_q[2:0];
  wire sw_rst = stc_wr && lk_data_q[srs_pkg::STCTL_SWRES];
  wire go_config = sw_rst || (stc_wr && (opst_in == srs_pkg::OPST_CONFIG));
  wire go_meas = stc_wr && !sw_rst && (opst_in == srs_pkg::OPST_MEAS);
  wire meas_next = go_meas || (in_meas && !go_config);

  // counter words only exist with time measurement in external sync mode
  wire tm_on = cfg2[srs_pkg::CFG2_TM_EN] &&
    (cfg3[srs_pkg::CFG3_MODE_HI:srs_pkg::CFG3_MODE_LO] == srs_pkg::MODE_EXT_SYNC);
  wire [3:0] last_res = tm_on ? srs_pkg::RES_LAST_TM : srs_pkg::RES_LAST_NO_TM;

  // state register readback: reserved and reset bits read zero, state field 010b or 011b
  wire [2:0] opst_rd = in_meas ? srs_pkg::OPST_MEAS : srs_pkg::OPST_CONFIG;
  wire [7:0] stc_rd = {stc_ss, stc_pd, 3'h0, opst_rd};

  // control bank read mux
  logic [7:0] cfg_byte;
  always_comb begin
    if (ptr == srs_pkg::ADDR_STCTL) begin
      cfg_byte = stc_rd;
    end else if (ptr == srs_pkg::ADDR_RSV1) begin
      cfg_byte = srs_pkg::RST_RSV1;
    end else if (ptr == srs_pkg::ADDR_GEN_ID) begin
      cfg_byte = GEN_ID;
    end else if (ptr == srs_pkg::ADDR_RSV3) begin
      cfg_byte = srs_pkg::RST_RSV3;
    end else if (ptr == srs_pkg::ADDR_RSV4) begin
      cfg_byte = srs_pkg::RST_RSV4;
    end else if (ptr == srs_pkg::ADDR_RSV5) begin
      cfg_byte = srs_pkg::RST_RSV5;
    end else if (ptr == srs_pkg::ADDR_CFG1) begin
      cfg_byte = cfg1;
    end else if (ptr == srs_pkg::ADDR_CFG2) begin
      cfg_byte = cfg2;
    end else if (ptr == srs_pkg::ADDR_CFG3) begin
      cfg_byte = cfg3;
    end else if (ptr == srs_pkg::ADDR_PAUSE) begin
      cfg_byte = pause;
    end else if (ptr == srs_pkg::ADDR_SYNC_EDGE_COUNT) begin
      cfg_byte = sync_edge_count;
    end else if (ptr == srs_pkg::ADDR_OPT) begin
      cfg_byte = opt;
    end else begin
      cfg_byte = srs_pkg::FILL_BYTE;
    end
  end

  // result bank read mux; a word is sent low byte first
  logic [15:0] res_word;
  always_comb begin
    if (ptr == srs_pkg::ADDR_STCTL) begin
      res_word = {status_i, stc_rd};
    end else if (ptr == srs_pkg::RES_TEMP) begin
      res_word = res_temp;
    end else if (ptr == srs_pkg::RES_X) begin
      res_word = res_x;
    end else if (ptr == srs_pkg::RES_Y) begin
      res_word = res_y;
    end else if (ptr == srs_pkg::RES_Z) begin
      res_word = res_z;
    end else if (ptr == srs_pkg::RES_CT_LO && tm_on) begin
      res_word = res_ct[15:0];
    end else if (ptr == srs_pkg::RES_CT_HI && tm_on) begin
      res_word = {srs_pkg::FILL_BYTE, res_ct[23:16]};
    end else begin
      res_word = {srs_pkg::FILL_BYTE, srs_pkg::FILL_BYTE};
    end
  end

  wire [7:0] next_rd_byte = in_meas ? (hi_phase ? res_word[15:8] : res_word[7:0]) : cfg_byte;

  // pointer after a read: byte steps in configuration, word steps in measurement
  wire [3:0] ptr_inc = ptr + 4'h1;
  wire [3:0] ptr_after_word = (ptr == last_res) ? srs_pkg::RES_WRAP : ptr_inc;
  wire [3:0] short_idx = in_meas ? srs_pkg::START_IDX_MEAS : srs_pkg::START_IDX_CFG;

  // handshake back to the link side; read byte is loaded with the ack
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      req_seen <= 1'b0;
      ack_tog <= 1'b0;
      rd_byte <= 8'h00;
    end else if (new_req) begin
      req_seen <= req_s;
      ack_tog <= ~ack_tog;
      if (do_rd) begin
        rd_byte <= next_rd_byte;
      end
    end
  end

  // address pointer and byte phase
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr <= srs_pkg::ADDR_STCTL;
      hi_phase <= 1'b0;
    end else if (do_ptr) begin
      ptr <= addr_in;
      hi_phase <= 1'b0;
    end else if (do_short) begin
      if (opt[srs_pkg::OPT_START_IDX]) begin
        ptr <= short_idx;
      end
      hi_phase <= 1'b0;
    end else if (do_wr) begin
      ptr <= ptr_inc;
      hi_phase <= 1'b0;
    end else if (do_rd && in_meas) begin
      hi_phase <= ~hi_phase;
      if (hi_phase) begin
        ptr <= ptr_after_word;
      end
    end else if (do_rd) begin
      ptr <= ptr_inc;
    end
  end

  // operating state, power-down, stored start bit
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= srs_pkg::SRS_ST_CONFIG;
      stc_ss <= srs_pkg::RST_STCTL[srs_pkg::STCTL_SS];
      stc_pd <= srs_pkg::RST_STCTL[srs_pkg::STCTL_PD];
    end else if (sw_rst) begin
      state <= srs_pkg::SRS_ST_CONFIG;
      stc_ss <= srs_pkg::RST_STCTL[srs_pkg::STCTL_SS];
      stc_pd <= srs_pkg::RST_STCTL[srs_pkg::STCTL_PD];
    end else if (stc_wr) begin
      state <= meas_next ? srs_pkg::SRS_ST_MEAS : srs_pkg::SRS_ST_CONFIG;
      stc_ss <= meas_next && lk_data_q[srs_pkg::STCTL_SS];
      stc_pd <= lk_data_q[srs_pkg::STCTL_PD];
    end
  end

  // start pulse only when the write leaves the device measuring
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_meas_o <= 1'b0;
    end else if (ce_i) begin
      start_meas_o <= stc_wr && !sw_rst && meas_next && lk_data_q[srs_pkg::STCTL_SS];
    end
  end

  // control bank; only written in configuration, software reset reloads it, other state changes leave it alone
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg1 <= srs_pkg::RST_CFG1;
      cfg2 <= srs_pkg::RST_CFG2;
      cfg3 <= srs_pkg::RST_CFG3;
      pause <= srs_pkg::RST_PAUSE;
      sync_edge_count <= srs_pkg::RST_SYNC_EDGE_COUNT;
      opt <= srs_pkg::RST_OPT;
    end else if (sw_rst) begin
      cfg1 <= srs_pkg::RST_CFG1;
      cfg2 <= srs_pkg::RST_CFG2;
      cfg3 <= srs_pkg::RST_CFG3;
      pause <= srs_pkg::RST_PAUSE;
      sync_edge_count <= srs_pkg::RST_SYNC_EDGE_COUNT;
      opt <= srs_pkg::RST_OPT;
    end else if (cfg_wr) begin
      if (ptr == srs_pkg::ADDR_CFG1) begin
        cfg1 <= lk_data_q;
      end
      if (ptr == srs_pkg::ADDR_CFG2) begin
        cfg2 <= lk_data_q;
      end
      if (ptr == srs_pkg::ADDR_CFG3) begin
        cfg3 <= lk_data_q;
      end
      if (ptr == srs_pkg::ADDR_PAUSE) begin
        pause <= lk_data_q;
      end
      if (ptr == srs_pkg::ADDR_SYNC_EDGE_COUNT) begin
        sync_edge_count <= lk_data_q;
      end
      if (ptr == srs_pkg::ADDR_OPT) begin
        opt <= lk_data_q;
      end
    end
  end

  // result capture at end of conversion; leaving for configuration clears them
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      res_temp <= 16'h0000;
      res_x <= 16'h0000;
      res_y <= 16'h0000;
      res_z <= 16'h0000;
      res_ct <= 24'h000000;
    end else if (go_config) begin
      res_temp <= 16'h0000;
      res_x <= 16'h0000;
      res_y <= 16'h0000;
      res_z <= 16'h0000;
      res_ct <= 24'h000000;
    end else if (ce_i && conv_done_i && in_meas) begin
      res_temp <= temp_i;
      res_x <= x_i;
      res_y <= y_i;
      res_z <= z_i;
      res_ct <= tm_on ? conv_time_i : 24'h000000;
    end
  end

  // ready: low through a conversion, high at its end or when measuring stops
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_o <= 1'b1;
    end else if (go_config) begin
      ready_o <= 1'b1;
    end else if (ce_i && conv_done_i && in_meas) begin
      ready_o <= 1'b1;
    end else if (ce_i && conv_start_i && in_meas) begin
      ready_o <= 1'b0;
    end
  end

  // control outputs straight from the registers
  assign meas_state_o = in_meas;
  assign power_down_o = stc_pd;
  assign config_gain_time_o = cfg1;
  assign config_second_o = cfg2;
  assign config_third_o = cfg3;
  assign inter_measure_pause_o = pause;
  assign sync_edge_count_o = sync_edge_count;
  assign option_settings_o = opt;

endmodule
`default_nettype wire

// ### dv/srs_regspace_sva.sv
`timescale 1ns/1ps
`default_nettype none
module srs_regspace_chk (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  input wire logic lk_cmd_valid_i,
  input wire logic lk_busy_o,
  input wire logic lk_rvalid_o,
  input wire logic conv_start_i,
  input wire logic conv_done_i,
  input wire logic ready_o,
  input wire logic meas_state_o,
  input wire logic power_down_o,
  input wire logic [7:0] config_gain_time_o,
  input wire logic [7:0] option_settings_o
);
  // system side: state, ready and the control copies
  reset_vals_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i) $rose(rst_b_i) |-> power_down_o && !meas_state_o
    && config_gain_time_o == 8'hA6 && option_settings_o == 8'h73) else $error("bad reset values");
  cfg_frozen_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i) meas_state_o && $past(meas_state_o)
    |-> $stable(config_gain_time_o) && $stable(option_settings_o)) else $error("config moved");
  cfg_ready_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i) !meas_state_o |-> ready_o)
    else $error("ready low in configuration");
  ready_fall_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i)
    ce_i && meas_state_o && conv_start_i && !conv_done_i |=> !ready_o) else $error("ready stuck");
  ready_rise_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i) ce_i && conv_done_i |=> ready_o)
    else $error("ready not back");
  ready_cause_a: assert property (
    @(posedge clock_i) disable iff (!rst_b_i) $fell(ready_o) |-> $past(conv_start_i))
    else $error("ready fell unasked");
  // link side handshake
  busy_take_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_b_i) lk_cmd_valid_i && !lk_busy_o |=> lk_busy_o)
    else $error("command not taken");
  busy_bound_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_b_i) $rose(lk_busy_o) |-> ##[1:12] !lk_busy_o)
    else $error("busy too long");
  rvalid_pulse_a: assert property (
    @(posedge link_clk_i) disable iff (!rst_b_i) lk_rvalid_o |-> !lk_busy_o ##1 !lk_rvalid_o)
    else $error("bad read pulse");
endmodule
bind srs_regspace srs_regspace_chk chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .link_clk_i(link_clk_i), .lk_cmd_valid_i(lk_cmd_valid_i), .lk_busy_o(lk_busy_o),
  .lk_rvalid_o(lk_rvalid_o), .conv_start_i(conv_start_i), .conv_done_i(conv_done_i),
  .ready_o(ready_o), .meas_state_o(meas_state_o), .power_down_o(power_down_o),
  .config_gain_time_o(config_gain_time_o), .option_settings_o(option_settings_o));
`default_nettype wire

// ### dv/srs_link_master.sv
`timescale 1ns/1ps
`default_nettype none
module srs_link_master (
  input wire logic link_clk_i,
  input wire logic lk_busy_i,
  input wire logic lk_rvalid_i,
  input wire logic [7:0] lk_rdata_i,
  output logic lk_cmd_valid_o,
  output logic [1:0] lk_cmd_o,
  output logic [7:0] lk_data_o
);
  initial begin
    lk_cmd_valid_o = 1'b0;
    lk_cmd_o = 2'h0;
    lk_data_o = 8'hA5;
  end
  // one command per call; data is scrambled once released so stale bytes never pass
  task automatic xfer(input logic [1:0] c, input logic [7:0] d, output logic [7:0] r);
    int n;
    r = 'x;
    n = 0;
    @(negedge link_clk_i);
    while (lk_busy_i && n < 30) begin
      n++;
      @(negedge link_clk_i);
    end
    lk_cmd_valid_o = 1'b1;
    lk_cmd_o = c;
    lk_data_o = d;
    @(negedge link_clk_i);
    lk_cmd_valid_o = 1'b0;
    lk_data_o = ~d;
    for (n = 0; n < 30; n++) begin
      if (c == 2'h2 ? lk_rvalid_i : !lk_busy_i) break;
      @(negedge link_clk_i);
    end
    if (lk_rvalid_i) r = lk_rdata_i;
  endtask
endmodule
`default_nettype wire

// ### dv/srs_regspace_tb.sv
`timescale 1ns/1ps
`default_nettype none
module srs_regspace_tb;
  localparam logic [7:0] GEN = 8'h3C; // arbitrary value
  logic clock_i = 1'b0;
  logic link_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cs = 1'b0;
  logic cd = 1'b0;
  logic ce = 1'b1;
  logic [7:0] st = 8'h5E;
  logic vld, busy, rvalid, ready, meas;
  logic [1:0] cmd;
  logic [7:0] dat, rdata, cg, c2;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  always #10 clock_i = ~clock_i;
  // link clock offset and on a 32 ns period against 20 ns, so its edges drift against the system clock
  initial begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  srs_regspace #(.GEN_ID(GEN)) dut (.clock_i(clock_i), .rst_b_i(rst_b), .ce_i(ce),
    .link_clk_i(link_clk), .lk_cmd_valid_i(vld), .lk_cmd_i(cmd), .lk_data_i(dat),
    .lk_busy_o(busy), .lk_rvalid_o(rvalid), .lk_rdata_o(rdata), .conv_start_i(cs),
    .conv_done_i(cd), .status_i(st), .temp_i(16'h0922), .x_i(16'hA1B2), .y_i(16'hC3D4),
    .z_i(16'hE5F6), .conv_time_i(24'h9A7B3C), .ready_o(ready), .meas_state_o(meas),
    .power_down_o(), .start_meas_o(), .config_gain_time_o(cg), .config_second_o(c2),
    .config_third_o(), .inter_measure_pause_o(), .sync_edge_count_o(), .option_settings_o());
  srs_link_master m (.link_clk_i(link_clk), .lk_busy_i(busy), .lk_rvalid_i(rvalid),
    .lk_rdata_i(rdata), .lk_cmd_valid_o(vld), .lk_cmd_o(cmd), .lk_data_o(dat));
  task automatic conclude();
    if (n_fail == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic op(input logic [1:0] c, input logic [7:0] d);
    logic [7:0] r;
    m.xfer(c, d, r);
  endtask
  task automatic rd(input logic [7:0] exp);
    logic [7:0] r;
    m.xfer(srs_pkg::CMD_RD, 8'h00, r);
    chk("read byte", exp, r);
  endtask
  // set the pointer, then read a run of bytes; result runs stay within 10 bytes
  task automatic rds(input logic [7:0] a, input logic [7:0] e[$]);
    op(srs_pkg::CMD_PTR, a);
    foreach (e[i]) rd(e[i]);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(srs_pkg::CMD_PTR, a);
    op(srs_pkg::CMD_WR, d);
  endtask
  // conversion pulses, driven on the falling edge
  task automatic conv();
    @(negedge clock_i) cs = 1'b1;
    @(negedge clock_i) cs = 1'b0;
    chk("ready low", 8'h00, {7'h00, ready});
    @(negedge clock_i) cd = 1'b1;
    @(negedge clock_i) cd = 1'b0;
    chk("ready high", 8'h01, {7'h00, ready});
  endtask
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(negedge clock_i);
    rst_b = 1'b1;
    rds(8'h00, '{8'h42, 8'h00, GEN, 8'h00, 8'hFF, 8'h80});
    rds(8'h06, '{8'hA6, 8'h40, 8'h40, 8'h19, 8'h01, 8'h73});
    wr(8'hF6, 8'h5B);
    op(srs_pkg::CMD_WR, 8'h41);
    op(srs_pkg::CMD_WR, 8'hC0);
    rds(8'h06, '{8'h5B, 8'h41, 8'hC0});
    chk("config2", 8'h41, c2);
    wr(8'h00, 8'h03);
    chk("meas", 8'h01, {7'h00, meas});
    wr(8'h06, 8'h11);
    chk("config1", 8'h5B, cg);
    conv();
    rds(8'h05, '{8'h3C, 8'h7B, 8'h9A, 8'h00, 8'hB2, 8'hA1});
    rds(8'h00, '{8'h03, 8'h5E, 8'h22, 8'h09, 8'hB2});
    rds(8'h0F, '{8'h00, 8'h00, 8'h03, 8'h5E});
    op(srs_pkg::CMD_SHORT, 8'h00);
    rd(8'hB2);
    wr(8'h00, 8'h02);
    chk("meas", 8'h00, {7'h00, meas});
    op(srs_pkg::CMD_SHORT, 8'h00);
    rd(8'h02);
    rds(8'h06, '{8'h5B});
    wr(8'h00, 8'h03);
    rds(8'h02, '{8'h00, 8'h00});
    wr(8'h00, 8'h0A);
    chk("config1", 8'hA6, cg);
    chk("meas", 8'h00, {7'h00, meas});
    wr(8'h07, 8'h00);
    wr(8'h00, 8'h83);
    conv();
    rds(8'h04, '{8'hF6, 8'hE5, 8'hB2});
    rds(8'h05, '{8'h00});
    // clock enable low must freeze ready against a start pulse
    @(negedge clock_i) ce = 1'b0;
    cs = 1'b1;
    @(negedge clock_i) cs = 1'b0;
    chk("ready frozen", 8'h01, {7'h00, ready});
    ce = 1'b1;
    conclude();
  end
endmodule
`default_nettype wire
